// ### rtl/sesc_main_oscillator_mon.sv
/*
 * Main-oscillator loss monitor: flags a failure when the synchronised
 * oscillator tick stops toggling for longer than the loss window.
 * Assumes the tick is a divided oscillator toggle already synchronised.
 */
`timescale 1ns/1ps
`include "sesc_regs.svh"
module sesc_main_oscillator_mon (
    // Clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic enable,
    // Oscillator tick, synchronised
    input wire logic tick,
    // One-cycle failure pulse
    output logic fail
);

    localparam logic [7:0] LOSS_CYC = 8'(`SESC_MAIN_OSCILLATOR_LOSS_CYC);

    logic tick_q;
    logic tick_d;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic fail_d;

    always_comb begin
        tick_d = tick_q;
        cnt_d = cnt_q;
        fail_d = 1'b0;
        if (ce) begin
            tick_d = tick;
            if (!enable || (tick != tick_q)) begin
                cnt_d = 8'h00;
            end else if (cnt_q != LOSS_CYC) begin
                cnt_d = cnt_q + 8'h01;
                // One report per loss; rearms on the next tick edge
                fail_d = (cnt_d == LOSS_CYC);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_q <= 1'b0;
            cnt_q <= 8'h00;
            fail <= 1'b0;
        end else begin
            tick_q <= tick_d;
            cnt_q <= cnt_d;
            fail <= fail_d;
        end
    end

endmodule // sesc_main_oscillator_mon

// ### rtl/sesc_pkg.sv
/*
 * Types of the system event and sleep clock block.
 * Assumes sesc_regs.svh for all numeric constants.
 */
package sesc_pkg;

    // Bit 0 is the PLL lock event, bit 6 the PLL failure event
    typedef struct packed {
        logic pll_failure_event;
        logic brownout_event;
        logic power_on_event;
        logic main_osc_failure_event;
        logic internal_osc_failure_event;
        logic regulator_current_limit_event;
        logic pll_locked_event;
    } sesc_evt_t;

    typedef enum logic [1:0] {
        SESC_SRC_MAIN = 2'h0,
        SESC_SRC_LFI = 2'h1,
        SESC_SRC_X32K = 2'h2
    } sesc_src_t;

    typedef struct packed {
        logic deep_sleep_precision_osc_powerdown;
        sesc_src_t src;
        logic [5:0] deep_sleep_clock_divider;
    } sesc_dslp_t;

    typedef struct packed {
        logic main_osc_no_crystal;
        logic main_osc_fail_irq_not_reset;
        logic main_osc_monitor_enable;
    } sesc_main_oscillator_t;

    typedef enum logic [1:0] {
        SESC_PM_RUN = 2'h0,
        SESC_PM_SLEEP = 2'h1,
        SESC_PM_DEEP = 2'h2
    } sesc_pm_t;

endpackage

// ### rtl/sesc_regs.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * system event and sleep clock block.
 * Assumes a 32-bit AXI4-Lite slave with byte addresses and a 40 MHz aclk.
 */
`ifndef SESC_REGS_SVH
`define SESC_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets
`define SESC_OFS_RAW 8'h00
`define SESC_OFS_MASK 8'h04
`define SESC_OFS_MIS 8'h08
`define SESC_OFS_DSLP 8'h0c
`define SESC_OFS_MAIN_OSCILLATOR 8'h10
`define SESC_OFS_SLEEP 8'h14
`define SESC_OFS_DSPER 8'h18
`define SESC_OFS_RUNOSC 8'h1c
`define SESC_OFS_STAT 8'h20

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define SESC_DSLP_DIV_LSB 0
`define SESC_DSLP_SRC_LSB 8
`define SESC_DSLP_PD_BIT 16
`define SESC_MAIN_OSCILLATOR_VAL_BIT 0
`define SESC_MAIN_OSCILLATOR_IRQ_BIT 1
`define SESC_MAIN_OSCILLATOR_NOX_BIT 2
`define SESC_SLP_GATE_BIT 0
`define SESC_SLP_REQ_BIT 8
`define SESC_SLP_DEEP_BIT 9
`define SESC_RUN_SRC_BIT 0
`define SESC_RUN_MDIS_BIT 1
`define SESC_RUN_PDIS_BIT 2
`define SESC_STAT_MON_BIT 4
`define SESC_STAT_PIO_BIT 5
`define SESC_STAT_HIB_BIT 6

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define SESC_RST_MASK 7'h00
`define SESC_RST_DIV 6'h00
`define SESC_RST_DSPER 32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// Timing
`define SESC_CLK_PERIOD_NS 25
`define SESC_MAIN_OSCILLATOR_LOSS_NS 2000
`define SESC_MAIN_OSCILLATOR_LOSS_CYC (`SESC_MAIN_OSCILLATOR_LOSS_NS / `SESC_CLK_PERIOD_NS)

`endif

// ### rtl/sesc_sync.sv
/*
 * Two-flop synchroniser for asynchronous levels.
 * Assumes every bit is an independent slow level.
 */
`timescale 1ns/1ps
module sesc_sync #(
    parameter int W = 1
) (
    // Clock and control
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] dout_d;

    always_comb begin
        meta_d = ce ? din : meta_q;
        dout_d = ce ? meta_q : dout;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= meta_d;
            dout <= dout_d;
        end
    end

endmodule // sesc_sync

// ### rtl/sesc_top.sv
/*
 * System event collector and sleep clock control with an AXI4-Lite slave.
 * Assumes asynchronous event, hibernation, oscillator tick and wake pins;
 * software on the processor owns the registers.
 */
`timescale 1ns/1ps
`include "sesc_regs.svh"
module sesc_top (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Asynchronous inputs
    input wire sesc_pkg::sesc_evt_t evt_pins,
    input wire logic hib_enabled,
    input wire logic main_osc_tick,
    input wire logic [31:0] periph_wake,
    // Processor side
    output logic irq,
    output logic proc_reset_req,
    output sesc_pkg::sesc_pm_t power_mode,
    // Clock tree control
    output sesc_pkg::sesc_src_t deep_sleep_src,
    output logic [5:0] deep_sleep_clock_divider,
    output logic main_osc_en,
    output logic main_osc_low_power,
    output logic precision_osc_en,
    output logic [31:0] periph_clk_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= `SESC_OFS_STAT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [40:0] sync_out;
    sesc_pkg::sesc_evt_t evt_s;
    logic hib_s;
    logic tick_s;
    logic [31:0] wake_s;
    logic mon_fail;
    logic mon_en_q;

    sesc_sync #(.W(41)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .din({evt_pins, hib_enabled, main_osc_tick, periph_wake}),
        .dout(sync_out)
    );

    assign evt_s = sync_out[40:34];
    assign hib_s = sync_out[33];
    assign tick_s = sync_out[32];
    assign wake_s = sync_out[31:0];

    sesc_main_oscillator_mon u_mon (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(mon_en_q),
        .tick(tick_s),
        .fail(mon_fail)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic [6:0] raw_q, raw_d, mask_q, mask_d;
    sesc_pkg::sesc_evt_t evt_prev_q, evt_prev_d;
    sesc_pkg::sesc_dslp_t dslp_q, dslp_d;
    sesc_pkg::sesc_main_oscillator_t main_oscillator_q, main_oscillator_d;
    logic gate_q, gate_d;
    logic [31:0] dsper_q, dsper_d;
    logic run_src_q, run_src_d, mdis_q, mdis_d, pdis_q, pdis_d;
    sesc_pkg::sesc_pm_t pm_d;
    logic mon_en_d, irq_d, rst_d, main_oscillator_on_d, pio_on_d;
    logic [31:0] clk_en_d;

    // Write strobe from the bus group
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;

    always_comb begin
        logic [31:0] w;
        logic [6:0] set;
        logic [6:0] clr;
        logic deep;
        logic wake;
        w = '0;
        wake = 1'b0;
        deep = 1'b0;
        set = evt_s & ~evt_prev_q;
        clr = '0;
        raw_d = raw_q;
        mask_d = mask_q;
        evt_prev_d = evt_prev_q;
        dslp_d = dslp_q;
        main_oscillator_d = main_oscillator_q;
        gate_d = gate_q;
        dsper_d = dsper_q;
        run_src_d = run_src_q;
        mdis_d = mdis_q;
        pdis_d = pdis_q;
        pm_d = power_mode;
        rst_d = 1'b0;
        if (ce) begin
            evt_prev_d = evt_s;
            if (mon_fail && main_oscillator_q.main_osc_fail_irq_not_reset) begin
                set[3] = 1'b1;
            end
            rst_d = mon_fail && !main_oscillator_q.main_osc_fail_irq_not_reset;
            if (wr_en) begin
                unique case (wr_addr)
                    `SESC_OFS_RAW: begin
                        clr = wr_data[6:0] & {7{wr_strb[0]}};
                    end
                    `SESC_OFS_MASK: begin
                        w = strb_merge({25'h0, mask_q}, wr_data, wr_strb);
                        mask_d = w[6:0];
                    end
                    `SESC_OFS_DSLP: begin
                        w = strb_merge({15'h0, dslp_q.deep_sleep_precision_osc_powerdown,
                                        6'h0, dslp_q.src, 2'h0,
                                        dslp_q.deep_sleep_clock_divider}, wr_data, wr_strb);
                        dslp_d.deep_sleep_clock_divider = w[5:0];
                        dslp_d.deep_sleep_precision_osc_powerdown = w[`SESC_DSLP_PD_BIT];
                        // External 32k only with hibernation up; else keep old source
                        if ((w[9:8] == 2'h0) || (w[9:8] == 2'h1) ||
                            ((w[9:8] == 2'h2) && hib_s)) begin
                            dslp_d.src = sesc_pkg::sesc_src_t'(w[9:8]);
                        end
                    end
                    `SESC_OFS_MAIN_OSCILLATOR: begin
                        w = strb_merge({29'h0, main_oscillator_q}, wr_data, wr_strb);
                        main_oscillator_d = w[2:0];
                    end
                    `SESC_OFS_SLEEP: begin
                        w = strb_merge({31'h0, gate_q}, wr_data, wr_strb);
                        gate_d = w[`SESC_SLP_GATE_BIT];
                        if (power_mode == sesc_pkg::SESC_PM_RUN) begin
                            if (w[`SESC_SLP_DEEP_BIT]) begin
                                pm_d = sesc_pkg::SESC_PM_DEEP;
                            end else if (w[`SESC_SLP_REQ_BIT]) begin
                                pm_d = sesc_pkg::SESC_PM_SLEEP;
                            end
                        end
                    end
                    `SESC_OFS_DSPER: begin
                        dsper_d = strb_merge(dsper_q, wr_data, wr_strb);
                    end
                    `SESC_OFS_RUNOSC: begin
                        w = strb_merge({29'h0, pdis_q, mdis_q, run_src_q}, wr_data, wr_strb);
                        run_src_d = w[`SESC_RUN_SRC_BIT];
                        mdis_d = w[`SESC_RUN_MDIS_BIT];
                        pdis_d = w[`SESC_RUN_PDIS_BIT];
                    end
                    default: begin
                    end
                endcase
            end
            raw_d = (raw_q & ~clr) | set; // set wins over clear
            // Wake on any interrupt; gated deep-sleep listens only to enabled peripherals
            wake = irq | (|(wake_s & ((power_mode == sesc_pkg::SESC_PM_DEEP && gate_q) ?
                                      dsper_q : 32'hffff_ffff)));
            unique case (power_mode)
                sesc_pkg::SESC_PM_RUN: begin
                end
                sesc_pkg::SESC_PM_SLEEP,
                sesc_pkg::SESC_PM_DEEP: begin
                    if (wake) begin
                        pm_d = sesc_pkg::SESC_PM_RUN;
                    end
                end
                default: begin
                    pm_d = sesc_pkg::SESC_PM_RUN;
                end
            endcase
        end
        deep = (pm_d == sesc_pkg::SESC_PM_DEEP);
        irq_d = |(raw_d & mask_d);
        // Oscillator in use is never switched off
        main_oscillator_on_d = (deep ? (dslp_d.src == sesc_pkg::SESC_SRC_MAIN) : !run_src_d) ||
                    (!mdis_d && !main_oscillator_d.main_osc_no_crystal);
        mon_en_d = main_oscillator_d.main_osc_monitor_enable && !main_oscillator_d.main_osc_no_crystal;
        // Monitor uses the precision oscillator as its reference, so it stays up
        pio_on_d = (!deep && run_src_d) || mon_en_d ||
                   (!pdis_d && !(deep && dslp_d.deep_sleep_precision_osc_powerdown));
        clk_en_d = (deep && gate_d) ? dsper_d : 32'hffff_ffff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_q <= 7'h00;
            mask_q <= `SESC_RST_MASK;
            evt_prev_q <= '0;
            dslp_q <= '{1'b0, sesc_pkg::SESC_SRC_MAIN, `SESC_RST_DIV};
            main_oscillator_q <= '0;
            gate_q <= 1'b0;
            dsper_q <= `SESC_RST_DSPER;
            run_src_q <= 1'b0;
            mdis_q <= 1'b0;
            pdis_q <= 1'b0;
            power_mode <= sesc_pkg::SESC_PM_RUN;
            irq <= 1'b0;
            proc_reset_req <= 1'b0;
            mon_en_q <= 1'b0;
            main_osc_en <= 1'b1;
            main_osc_low_power <= 1'b0;
            precision_osc_en <= 1'b1;
            periph_clk_en <= 32'hffff_ffff;
            deep_sleep_src <= sesc_pkg::SESC_SRC_MAIN;
            deep_sleep_clock_divider <= `SESC_RST_DIV;
        end else begin
            raw_q <= raw_d;
            mask_q <= mask_d;
            evt_prev_q <= evt_prev_d;
            dslp_q <= dslp_d;
            main_oscillator_q <= main_oscillator_d;
            gate_q <= gate_d;
            dsper_q <= dsper_d;
            run_src_q <= run_src_d;
            mdis_q <= mdis_d;
            pdis_q <= pdis_d;
            power_mode <= pm_d;
            irq <= irq_d;
            proc_reset_req <= rst_d;
            mon_en_q <= mon_en_d;
            main_osc_en <= main_oscillator_on_d;
            main_osc_low_power <= main_oscillator_d.main_osc_no_crystal;
            precision_osc_en <= pio_on_d;
            periph_clk_en <= clk_en_d;
            deep_sleep_src <= dslp_d.src;
            deep_sleep_clock_divider <= dslp_d.deep_sleep_clock_divider;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: one write and one read in flight

    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] aw_addr_q, aw_addr_d;
    logic [31:0] w_data_q, w_data_d;
    logic [3:0] w_strb_q, w_strb_d;
    logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
    logic [1:0] bresp_d, rresp_d;
    logic [31:0] rdata_d;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        aw_addr_d = aw_addr_q;
        w_data_d = w_data_q;
        w_strb_d = w_strb_q;
        bvalid_d = s_axi_bvalid;
        bresp_d = s_axi_bresp;
        rvalid_d = s_axi_rvalid;
        rresp_d = s_axi_rresp;
        rdata_d = s_axi_rdata;
        wr_en = 1'b0;
        if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_d = 1'b1;
                aw_addr_d = s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_d = 1'b1;
                w_data_d = s_axi_wdata;
                w_strb_d = s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                bvalid_d = 1'b0;
            end
            if (aw_have_d && w_have_d && !s_axi_bvalid) begin
                wr_en = mapped(aw_addr_d);
                bresp_d = mapped(aw_addr_d) ? 2'h0 : 2'h2;
                bvalid_d = 1'b1;
                aw_have_d = 1'b0;
                w_have_d = 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                rvalid_d = 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_d = 1'b1;
                rresp_d = mapped(s_axi_araddr) ? 2'h0 : 2'h2;
                unique case (s_axi_araddr)
                    `SESC_OFS_RAW: rdata_d = {25'h0, raw_q};
                    `SESC_OFS_MASK: rdata_d = {25'h0, mask_q};
                    `SESC_OFS_MIS: rdata_d = {25'h0, raw_q & mask_q};
                    `SESC_OFS_DSLP: rdata_d = {15'h0, dslp_q.deep_sleep_precision_osc_powerdown,
                                               6'h0, dslp_q.src, 2'h0,
                                               dslp_q.deep_sleep_clock_divider};
                    `SESC_OFS_MAIN_OSCILLATOR: rdata_d = {29'h0, main_oscillator_q};
                    `SESC_OFS_SLEEP: rdata_d = {31'h0, gate_q};
                    `SESC_OFS_DSPER: rdata_d = dsper_q;
                    `SESC_OFS_RUNOSC: rdata_d = {29'h0, pdis_q, mdis_q, run_src_q};
                    `SESC_OFS_STAT: rdata_d = {25'h0, hib_s, precision_osc_en, mon_en_q,
                                               1'b0, main_osc_en, power_mode};
                    default: rdata_d = 32'h0000_0000;
                endcase
            end
        end
        awready_d = ce ? (!aw_have_d && !bvalid_d) : s_axi_awready;
        wready_d = ce ? (!w_have_d && !bvalid_d) : s_axi_wready;
        arready_d = ce ? !rvalid_d : s_axi_arready;
        wr_addr = aw_addr_d;
        wr_data = w_data_d;
        wr_strb = w_strb_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            aw_addr_q <= aw_addr_d;
            w_data_q <= w_data_d;
            w_strb_q <= w_strb_d;
            s_axi_awready <= awready_d;
            s_axi_wready <= wready_d;
            s_axi_bvalid <= bvalid_d;
            s_axi_bresp <= bresp_d;
            s_axi_arready <= arready_d;
            s_axi_rvalid <= rvalid_d;
            s_axi_rresp <= rresp_d;
            s_axi_rdata <= rdata_d;
        end
    end

endmodule // sesc_top

// ### testbench/sesc_props.sv
/* Checker of sesc_top: bus handshakes, sleep entry and wake, failure pulse.
   Assumes binding to sesc_top; ce may drop during the run. */
`timescale 1ns/1ps
module sesc_props (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    // Processor side
    input wire logic irq,
    input wire logic proc_reset_req,
    input wire sesc_pkg::sesc_pm_t power_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
    endsequence
    sequence s_rd;
        s_axi_arvalid && s_axi_arready && ce;
    endsequence
    sequence s_sleep_irq;
        power_mode != sesc_pkg::SESC_PM_RUN && irq && ce;
    endsequence
    property p_wlat; s_wr |=> s_axi_bvalid; endproperty
    property p_awref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    // Readies come back at the very edge the answer is taken
    property p_bgap; $fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready; endproperty
    property p_rlat; s_rd |=> s_axi_rvalid; endproperty
    property p_arref; s_axi_rvalid |-> !s_axi_arready; endproperty
    // Failure to reset is a single pulse; the monitor rearms on a tick edge or when disabled
    property p_preq; proc_reset_req |=> !proc_reset_req; endproperty
    property p_wake; s_sleep_irq |=> power_mode == sesc_pkg::SESC_PM_RUN; endproperty
    // Sleep is entered only with a register write answer
    property p_entry;
        power_mode != sesc_pkg::SESC_PM_RUN && $past(power_mode) == sesc_pkg::SESC_PM_RUN
            |-> s_axi_bvalid || $past(s_axi_bvalid);
    endproperty
    a_wlat: assert property (p_wlat) else $error("write answer late");
    a_awref: assert property (p_awref) else $error("write taken early");
    a_bgap: assert property (p_bgap) else $error("write ready late");
    a_rlat: assert property (p_rlat) else $error("read answer late");
    a_arref: assert property (p_arref) else $error("read taken early");
    a_preq: assert property (p_preq) else $error("reset pulse long");
    a_wake: assert property (p_wake) else $error("no wake on irq");
    a_entry: assert property (p_entry) else $error("sleep without request");
endmodule // sesc_props
bind sesc_top sesc_props u_props (.*);

// ### testbench/sesc_top_test.sv
/* Self-checking bench of sesc_top over AXI4-Lite.
   Assumes the bench drives every input; no far-side model. */
`timescale 1ns/1ps
module sesc_top_test;
    logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, periph_wake = '0, periph_clk_en;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_bready = 1'h1, s_axi_rready = 1'h1, hib_enabled = 1'h0, main_osc_tick = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic irq, proc_reset_req, main_osc_en, main_osc_low_power, precision_osc_en;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [5:0] deep_sleep_clock_divider;
    sesc_pkg::sesc_evt_t evt_pins = '0;
    sesc_pkg::sesc_pm_t power_mode;
    sesc_pkg::sesc_src_t deep_sleep_src;
    int num_errors = 0, checked = 0, cycles = 0, n;
    sesc_top uut (.*);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    task automatic summarize;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Run is about 300 cycles; the ceiling leaves ample margin
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize;
        end
    end
    task automatic ck(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // Address and data go up together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 1'h0;
        wd = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            ad |= s_axi_awready;
            wd |= s_axi_wready;
            if (ad) s_axi_awvalid <= 1'h0;
            if (wd) s_axi_wvalid <= 1'h0;
        end while (!(ad && wd));
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rsp = s_axi_rresp;
        ck(nm, s_axi_rdata, e);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(4);
        aresetn <= 1'h1;
        cyc(1);
        rc(8'h04, '0, "mask");
        rc(8'h20, 32'h24, "stat");
        rc(8'h24, '0, "unmapped");
        ck("resp", rsp, 2'h2);
        evt_pins <= 7'h7f;
        cyc(4);
        rc(8'h00, 32'h7f, "raw");
        ck("irq masked", irq, 1'h0);
        wr(8'h04, 32'h05);
        ck("bresp", rsp, 2'h0);
        wr(8'h24, 32'h1);
        ck("wresp", rsp, 2'h2);
        rc(8'h08, 32'h05, "masked");
        ck("irq", irq, 1'h1);
        wr(8'h14, 32'h100);
        ck("sleep", power_mode, sesc_pkg::SESC_PM_SLEEP);
        cyc(3);
        ck("wake", power_mode, sesc_pkg::SESC_PM_RUN);
        wr(8'h00, 32'h01);
        rc(8'h00, 32'h7e, "clear");
        ck("irq held", irq, 1'h1);
        wr(8'h00, 32'h7e);
        cyc(2);
        ck("irq clear", irq, 1'h0);
        evt_pins <= '0;
        cyc(4);
        // Clock enable low must hold the pin edge back
        ce <= 1'h0;
        evt_pins <= 7'h01;
        cyc(6);
        ck("frozen", irq, 1'h0);
        ce <= 1'h1;
        cyc(6);
        ck("thawed", irq, 1'h1);
        wr(8'h00, 32'h01);
        evt_pins <= '0;
        wr(8'h0c, 32'h1013f);
        wr(8'h0c, 32'h1023f);
        rc(8'h0c, 32'h1013f, "dslp");
        ck("div", deep_sleep_clock_divider, 6'h3f);
        hib_enabled <= 1'h1;
        cyc(3);
        wr(8'h0c, 32'h10200);
        ck("src", deep_sleep_src, sesc_pkg::SESC_SRC_X32K);
        // Bit 0 wakes only if the deep-sleep set lets it through
        wr(8'h18, 32'h2);
        periph_wake <= 32'h1;
        wr(8'h14, 32'h201);
        cyc(5);
        ck("deep", power_mode, sesc_pkg::SESC_PM_DEEP);
        ck("pclk", periph_clk_en, 32'h2);
        ck("posc", precision_osc_en, 1'h0);
        periph_wake <= 32'h3;
        cyc(5);
        ck("run", power_mode, sesc_pkg::SESC_PM_RUN);
        periph_wake <= '0;
        wr(8'h1c, 32'h2);
        cyc(2);
        ck("main_oscillator kept", main_osc_en, 1'h1);
        wr(8'h10, 32'h1);
        rc(8'h20, 32'h74, "mon on");
        n = 0;
        while (proc_reset_req !== 1'h1 && n < 200) begin
            cyc(1);
            n++;
        end
        ck("reset req", proc_reset_req, 1'h1);
        wr(8'h10, 32'h3);
        main_osc_tick <= 1'h1;
        cyc(120);
        rc(8'h00, 32'h08, "main_oscillator fail");
        wr(8'h10, 32'h7);
        cyc(2);
        ck("low power", main_osc_low_power, 1'h1);
        rc(8'h20, 32'h64, "mon off");
        summarize;
    end
endmodule // sesc_top_test
